/* rtl/swp_pkg.sv */
// Package for the standby and write-protect controller
package swp_pkg;
  // Register byte offsets (printed offsets are not multiples of four: index * 4)
  localparam logic [7:0] PROT_STATUS_IDX = 8'he3;
  localparam logic [7:0] PROT_KEY_IDX    = 8'he4;
  localparam logic [7:0] SYS_CTRL0_IDX   = 8'he0;
  localparam logic [7:0] SYS_CTRL1_IDX   = 8'he1;
  localparam logic [7:0] SYS_CTRL2_IDX   = 8'he2;
  localparam logic [9:0] PROT_STATUS_ADR = {PROT_STATUS_IDX, 2'b00};
  localparam logic [9:0] PROT_KEY_ADR    = {PROT_KEY_IDX, 2'b00};
  localparam logic [9:0] SYS_CTRL0_ADR   = {SYS_CTRL0_IDX, 2'b00};
  localparam logic [9:0] SYS_CTRL1_ADR   = {SYS_CTRL1_IDX, 2'b00};
  localparam logic [9:0] SYS_CTRL2_ADR   = {SYS_CTRL2_IDX, 2'b00};
  localparam logic [9:0] IDLE_EN_ADR     = 10'h100;
  localparam logic [9:0] STBY_STAT_ADR   = 10'h104;
  localparam logic [9:0] IRQ_STAT_ADR    = 10'h108;
  localparam logic [9:0] IRQ_MASK_ADR    = 10'h10c;
  // Field positions and values
  localparam int unsigned PROT_FLAG_BIT  = 7;
  localparam logic [7:0] UNLOCK_CODE     = 8'h1f;
  localparam logic [6:0] PROT_STATUS_RST = 7'h23;
  localparam logic [7:0] SYS_CTRL0_RST   = 8'h80;
  localparam logic [7:0] SYS_CTRL1_RST   = 8'h00;
  localparam logic [7:0] SYS_CTRL2_RST   = 8'h2c;
  localparam int unsigned HALT_SEL_LSB   = 2;
  localparam int unsigned WUP_SEL_LSB    = 4;
  // Timing: entry window of about five peripheral clocks
  localparam int unsigned ENTRY_CLOCKS   = 5;
  localparam logic [3:0]  WUP_COUNT_W    = 4'd8;
  localparam logic [2:0]  NMI_LEVEL      = 3'h7;

  typedef enum logic [1:0] {
    SWP_HALT_NONE  = 2'b00,
    SWP_HALT_STOP  = 2'b01,
    SWP_HALT_LIGHT = 2'b10,
    SWP_HALT_IDLE  = 2'b11
  } swp_halt_e;

  typedef enum logic [2:0] {
    SWP_RUN   = 3'b000,
    SWP_ENTER = 3'b001,
    SWP_HALT  = 3'b010,
    SWP_WARM  = 3'b011,
    SWP_WAKE  = 3'b100
  } swp_state_e;

  // Interrupt request from the interrupt controller
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic       nmi;
    logic       ext0;
    logic       rtc;
    logic       idle_capable;
    logic       light_capable;
    logic       stop_capable;
  } swp_irq_s;

  // Wake order to the CPU core
  typedef struct packed {
    logic       wake;
    logic       service;
    logic       from_held;
  } swp_wake_s;
endpackage : swp_pkg

/* rtl/swp_ctrl.sv */
// Standby controller and write-protect latch with Wishbone registers
// Behaviour
// - Non-unlock key write sets protection latch
// - Unlock code key write clears latch
// - Latch suppresses writes to guarded registers
// - Latch readable as status bit seven
// - Halt enters level chosen by select field
// - CPU-only idle keeps enabled units running
// - Light sleep stops clock, oscillator/RTC run
// - Full stop halts everything including oscillator
// - Port outputs hold during any halt
// - Exit by reset or qualifying interrupt
// - Unmasked qualifying interrupt wakes and serviced
// - Masked interrupt keeps halt, except special sources
// - Non-maskable always wakes and is serviced
// - Masked ext0, or RTC outside full stop, wake without service, pending
// - First entry-window NMI/ext0/RTC wake is held pending
// - Held versus later: higher priority first
// - Full-stop exit waits oscillator warm-up
// - Reset initialises all; interrupt keeps state
module swp_ctrl #(
  parameter int unsigned WARMUP_CYCLES = 4096,
  parameter int unsigned IDLE_UNITS    = 13
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  input  wire logic              halt_exec_i,
  input  wire logic [2:0]        irq_mask_level_i,
  input  wire swp_pkg::swp_irq_s irq_i,
  input  wire logic [7:0]        port_out_i,
  output logic      [7:0]        port_out_o,
  output swp_pkg::swp_wake_s     wake_o,
  output logic                   cpu_run_o,
  output logic                   sys_clk_en_o,
  output logic                   osc_en_o,
  output logic                   rtc_en_o,
  output logic [IDLE_UNITS-1:0]  unit_run_o,
  output logic [7:0]             sys_control_0_o,
  output logic [7:0]             sys_control_1_o,
  output logic [7:0]             sys_control_2_o,
  output logic                   irq_o
);

  logic                  protect;
  logic [6:0]            prot_spare;
  logic [7:0]            sys_control_0;
  logic [7:0]            sys_control_1;
  logic [7:0]            sys_control_2;
  logic [IDLE_UNITS-1:0] idle_enable;
  logic [3:0]            irq_stat;
  logic [3:0]            next_irq_stat;
  logic [3:0]            irq_mask;
  swp_pkg::swp_state_e   state;
  swp_pkg::swp_halt_e    level;
  logic [2:0]            entry_cnt;
  logic [15:0]           warm_cnt;
  logic                  held;
  logic [2:0]            held_level;
  logic                  held_nmi;
  logic                  held_service;
  logic                  pend_svc;
  logic                  pend_lvl_valid;
  logic [2:0]            pend_level;
  logic                  wr_stb;
  logic                  rd_stb;
  logic                  byte_wr;
  logic [9:0]            adr;
  logic                  mapped;
  logic                  qual;
  logic                  svc;
  logic                  special;
  logic                  supp_wr;
  logic [3:0]            ev;

  assign adr     = wb_adr_i[9:0];
  assign wr_stb  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_we_i;
  assign rd_stb  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !wb_we_i;
  assign byte_wr = wr_stb && wb_sel_i[0];

  function automatic logic is_guarded(input logic [9:0] a);
    is_guarded = (a == swp_pkg::SYS_CTRL0_ADR) || (a == swp_pkg::SYS_CTRL1_ADR) ||
                 (a == swp_pkg::SYS_CTRL2_ADR);
  endfunction : is_guarded

  function automatic logic is_mapped(input logic [9:0] a);
    is_mapped = is_guarded(a) || (a == swp_pkg::PROT_STATUS_ADR) ||
                (a == swp_pkg::PROT_KEY_ADR) || (a == swp_pkg::IDLE_EN_ADR) ||
                (a == swp_pkg::STBY_STAT_ADR) || (a == swp_pkg::IRQ_STAT_ADR) ||
                (a == swp_pkg::IRQ_MASK_ADR);
  endfunction : is_mapped

  assign mapped  = is_mapped(adr) && (wb_adr_i[31:10] == 22'h000000);
  assign supp_wr = protect && is_guarded(adr);

  // Qualification of the current request for the active halt level
  always_comb begin
    svc     = 1'b0;
    special = 1'b0;
    qual    = 1'b0;
    if (irq_i.valid) begin
      if (irq_i.nmi) begin
        svc = 1'b1;
      end else if (irq_i.level >= irq_mask_level_i) begin
        case (level)
          swp_pkg::SWP_HALT_IDLE:  svc = irq_i.idle_capable;
          swp_pkg::SWP_HALT_LIGHT: svc = irq_i.light_capable;
          swp_pkg::SWP_HALT_STOP:  svc = irq_i.stop_capable;
          default:                 svc = 1'b0;
        endcase
      end else begin
        special = irq_i.ext0 || (irq_i.rtc && level != swp_pkg::SWP_HALT_STOP);
      end
      qual = svc || special;
    end
  end

  // Protection latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      protect <= 1'b0;
    end else if (byte_wr && mapped && adr == swp_pkg::PROT_KEY_ADR) begin
      protect <= (wb_dat_i[7:0] != swp_pkg::UNLOCK_CODE);
    end
  end

  // Software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prot_spare    <= swp_pkg::PROT_STATUS_RST;
      sys_control_0 <= swp_pkg::SYS_CTRL0_RST;
      sys_control_1 <= swp_pkg::SYS_CTRL1_RST;
      sys_control_2 <= swp_pkg::SYS_CTRL2_RST;
      idle_enable   <= '0;
      irq_mask      <= 4'h0;
    end else if (byte_wr && mapped && !supp_wr) begin
      case (adr)
        swp_pkg::PROT_STATUS_ADR: prot_spare    <= wb_dat_i[6:0];
        swp_pkg::SYS_CTRL0_ADR:   sys_control_0 <= wb_dat_i[7:0];
        swp_pkg::SYS_CTRL1_ADR:   sys_control_1 <= wb_dat_i[7:0];
        swp_pkg::SYS_CTRL2_ADR:   sys_control_2 <= wb_dat_i[7:0];
        swp_pkg::IDLE_EN_ADR:     idle_enable   <= wb_dat_i[IDLE_UNITS-1:0];
        swp_pkg::IRQ_MASK_ADR:    irq_mask      <= wb_dat_i[3:0];
        default:                  irq_mask      <= irq_mask;
      endcase
    end
  end

  // Standby sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= swp_pkg::SWP_RUN;
      level        <= swp_pkg::SWP_HALT_NONE;
      entry_cnt    <= 3'h0;
      warm_cnt     <= 16'h0000;
      held         <= 1'b0;
      held_level   <= 3'h0;
      held_nmi     <= 1'b0;
      held_service <= 1'b0;
      pend_svc     <= 1'b0;
      pend_lvl_valid <= 1'b0;
      pend_level   <= 3'h0;
      wake_o       <= '0;
    end else begin
      wake_o <= '0;
      case (state)
        swp_pkg::SWP_RUN: begin
          if (halt_exec_i) begin
            level <= swp_pkg::swp_halt_e'(sys_control_2[swp_pkg::HALT_SEL_LSB +: 2]);
            if (sys_control_2[swp_pkg::HALT_SEL_LSB +: 2] == 2'b00) begin
              state <= swp_pkg::SWP_RUN;
            end else if (sys_control_2[swp_pkg::HALT_SEL_LSB +: 2] == 2'b11) begin
              state <= swp_pkg::SWP_HALT;
            end else begin
              state     <= swp_pkg::SWP_ENTER;
              entry_cnt <= 3'h0;
            end
          end
        end
        swp_pkg::SWP_ENTER: begin
          if (qual && !held && (irq_i.nmi || irq_i.ext0 || irq_i.rtc)) begin
            held         <= 1'b1;
            held_level   <= irq_i.nmi ? swp_pkg::NMI_LEVEL : irq_i.level;
            held_nmi     <= irq_i.nmi;
            held_service <= svc;
          end
          entry_cnt <= entry_cnt + 3'h1;
          if (entry_cnt == 3'(swp_pkg::ENTRY_CLOCKS - 1)) begin
            state <= swp_pkg::SWP_HALT;
          end
        end
        swp_pkg::SWP_HALT: begin
          if (qual) begin
            pend_svc       <= svc;
            pend_lvl_valid <= 1'b1;
            pend_level     <= irq_i.nmi ? swp_pkg::NMI_LEVEL : irq_i.level;
            if (level == swp_pkg::SWP_HALT_STOP) begin
              state    <= swp_pkg::SWP_WARM;
              warm_cnt <= 16'h0000;
            end else begin
              state <= swp_pkg::SWP_WAKE;
            end
          end
        end
        swp_pkg::SWP_WARM: begin
          warm_cnt <= warm_cnt + 16'h0001;
          if (warm_cnt == 16'(WARMUP_CYCLES - 1)) begin
            state <= swp_pkg::SWP_WAKE;
          end
        end
        swp_pkg::SWP_WAKE: begin
          // Held request first when it outranks the waking one
          if (held && (held_nmi || !pend_lvl_valid || held_level > pend_level)) begin
            wake_o <= '{wake: 1'b1, service: held_service, from_held: 1'b1};
            held   <= 1'b0;
          end else begin
            wake_o         <= '{wake: pend_lvl_valid, service: pend_svc, from_held: 1'b0};
            pend_lvl_valid <= 1'b0;
            if (!held) begin
              state <= swp_pkg::SWP_RUN;
              level <= swp_pkg::SWP_HALT_NONE;
            end
          end
        end
        default: state <= swp_pkg::SWP_RUN;
      endcase
    end
  end

  // Clock and unit gating outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_run_o    <= 1'b1;
      sys_clk_en_o <= 1'b1;
      osc_en_o     <= 1'b1;
      rtc_en_o     <= 1'b1;
      unit_run_o   <= '1;
    end else if (state == swp_pkg::SWP_HALT || state == swp_pkg::SWP_WARM) begin
      cpu_run_o    <= 1'b0;
      sys_clk_en_o <= (level == swp_pkg::SWP_HALT_IDLE);
      osc_en_o     <= (level != swp_pkg::SWP_HALT_STOP) || (state == swp_pkg::SWP_WARM);
      rtc_en_o     <= (level != swp_pkg::SWP_HALT_STOP);
      unit_run_o   <= (level == swp_pkg::SWP_HALT_IDLE) ? idle_enable : '0;
    end else begin
      cpu_run_o    <= (state == swp_pkg::SWP_RUN);
      sys_clk_en_o <= 1'b1;
      osc_en_o     <= 1'b1;
      rtc_en_o     <= 1'b1;
      unit_run_o   <= '1;
    end
  end

  // Port outputs freeze while halted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_out_o <= 8'h00;
    end else if (state == swp_pkg::SWP_RUN && !halt_exec_i) begin
      port_out_o <= port_out_i;
    end
  end

  // Event status: bit0 halt executed in run (any select), bit1 wake, bit2 held request, bit3 guarded write blocked
  assign ev = {byte_wr && mapped && supp_wr,
               state == swp_pkg::SWP_ENTER && qual && !held &&
               (irq_i.nmi || irq_i.ext0 || irq_i.rtc),
               wake_o.wake,
               state == swp_pkg::SWP_RUN && halt_exec_i};

  // Write-one-to-clear; a new event in the same cycle wins
  always_comb begin
    next_irq_stat = irq_stat | ev;
    if (byte_wr && mapped && adr == swp_pkg::IRQ_STAT_ADR) begin
      next_irq_stat = (irq_stat & ~wb_dat_i[3:0]) | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Follows the status register in the same cycle, clears included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_irq_stat & irq_mask);
    end
  end

  // Bus answer: one cycle after the strobe, one-cycle ack or err
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= (wr_stb || rd_stb) && mapped;
      wb_err_o <= (wr_stb || rd_stb) && !mapped;
      wb_dat_o <= 32'h00000000;
      if (rd_stb) begin
        case (adr)
          swp_pkg::PROT_STATUS_ADR: wb_dat_o <= {24'h000000, protect, prot_spare};
          swp_pkg::SYS_CTRL0_ADR:   wb_dat_o <= {24'h000000, sys_control_0};
          swp_pkg::SYS_CTRL1_ADR:   wb_dat_o <= {24'h000000, sys_control_1};
          swp_pkg::SYS_CTRL2_ADR:   wb_dat_o <= {24'h000000, sys_control_2};
          swp_pkg::IDLE_EN_ADR:     wb_dat_o <= 32'(idle_enable);
          swp_pkg::STBY_STAT_ADR:   wb_dat_o <= {24'h000000, 2'b00, held, level, state};
          swp_pkg::IRQ_STAT_ADR:    wb_dat_o <= {28'h0000000, irq_stat};
          swp_pkg::IRQ_MASK_ADR:    wb_dat_o <= {28'h0000000, irq_mask};
          default:                  wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  assign sys_control_0_o = sys_control_0;
  assign sys_control_1_o = sys_control_1;
  assign sys_control_2_o = sys_control_2;

endmodule : swp_ctrl

/* dv/swp_ctrl_assertions.sv */
// Concurrent checks on the standby controller ports
module swp_ctrl_checker (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               halt_exec_i,
  input wire logic [7:0]         port_out_o,
  input wire swp_pkg::swp_wake_s wake_o,
  input wire logic               cpu_run_o,
  input wire logic               sys_clk_en_o,
  input wire logic               osc_en_o,
  input wire logic               rtc_en_o,
  input wire logic [7:0]         sys_control_2_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] lvl;
  assign lvl = sys_control_2_o[3:2];
  a_port_hold: assert property (!cpu_run_o && !$past(cpu_run_o) |-> $stable(port_out_o))
    else $error("port outputs moved while halted");
  a_light_clocks: assert property (!sys_clk_en_o && lvl == 2'b10 |-> osc_en_o && rtc_en_o)
    else $error("light sleep stopped oscillator or rtc");
  a_osc_off_all: assert property (!osc_en_o |-> !sys_clk_en_o && !rtc_en_o)
    else $error("circuit running with oscillator off");
  a_warm_up: assert property ($rose(osc_en_o) |-> !sys_clk_en_o [*4])
    else $error("system clock before warm-up");
  a_idle_entry: assert property (halt_exec_i && cpu_run_o && lvl == 2'b11
    |-> ##[1:3] (!cpu_run_o && sys_clk_en_o)) else $error("idle level entry wrong");
  a_deep_entry: assert property (halt_exec_i && cpu_run_o && (lvl == 2'b10 || lvl == 2'b01)
    |-> ##[1:8] !sys_clk_en_o) else $error("sleep level did not stop clock");
  a_none_entry: assert property (halt_exec_i && cpu_run_o && lvl == 2'b00 |=> cpu_run_o [*4])
    else $error("reserved select halted the core");
  a_wake_resume: assert property (wake_o.wake |-> ##[0:3] cpu_run_o)
    else $error("core not resumed after wake");
  c_wake_svc: cover property (wake_o.wake && wake_o.service);
  c_wake_plain: cover property (wake_o.wake && !wake_o.service);
  c_wake_held: cover property (wake_o.wake && wake_o.from_held);
endmodule : swp_ctrl_checker

bind swp_ctrl swp_ctrl_checker u_chk (.clk_i, .rst_i, .halt_exec_i, .port_out_o, .wake_o,
  .cpu_run_o, .sys_clk_en_o, .osc_en_o, .rtc_en_o, .sys_control_2_o);

/* dv/swp_cpu_model.sv */
// Behavioural CPU core and interrupt controller facing the standby controller
module swp_cpu_model (
  input  wire logic               clk_i,
  input  wire swp_pkg::swp_wake_s wake_i,
  output logic                    halt_o,
  output logic [2:0]              mask_o,
  output swp_pkg::swp_irq_s       irq_o,
  output logic [7:0]              port_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int         wakes = 0;
  logic       last_svc = 1'b0;
  logic [1:0] hist = 2'b00;
  initial begin
    halt_o = 1'b0;
    mask_o = 3'h0;
    irq_o  = '0;
    port_o = 8'h00;
  end
  // Port values change every cycle so a frozen copy is visible
  always @(posedge clk_i) begin
    port_o <= port_o + 8'h01;
    if (wake_i.wake === 1'b1) begin
      wakes++;
      last_svc = wake_i.service;
      hist = {hist[0], wake_i.from_held};
    end
  end
  task automatic halt();
    @(posedge clk_i);
    halt_o <= 1'b1;
    @(posedge clk_i);
    halt_o <= 1'b0;
  endtask : halt
  // Holds a request until a wake arrives or n cycles pass
  task automatic req(input swp_pkg::swp_irq_s r, input logic [2:0] m, input int n,
                     output int c);
    int w;
    w = wakes;
    @(posedge clk_i);
    mask_o <= m;
    irq_o  <= r;
    for (c = 0; c < n && wakes == w; c++) @(posedge clk_i);
    irq_o <= '0;
  endtask : req
endmodule : swp_cpu_model

/* dv/test_standby_and_write_protect_ctrl.sv */
// Register and standby tests for the standby and write-protect controller
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_standby_and_write_protect_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o;
  logic [3:0]  wb_sel_i = 4'h0;
  logic wb_ack_o, wb_err_o, halt_exec_i, cpu_run_o, sys_clk_en_o, osc_en_o, rtc_en_o, irq_o;
  logic [2:0]  irq_mask_level_i;
  logic [7:0]  port_out_i, port_out_o, sys_control_0_o, sys_control_1_o, sys_control_2_o, p;
  logic [12:0] unit_run_o;
  logic [31:0] q;
  logic        e;
  logic [1:0]  lv [3] = '{2'b11, 2'b10, 2'b01};
  swp_pkg::swp_irq_s  irq_i;
  swp_pkg::swp_wake_s wake_o;
  int failures = 0, cmp_count = 0, c, w;
  always #25 clk_i = ~clk_i;
  swp_ctrl #(.WARMUP_CYCLES(8)) dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .halt_exec_i, .irq_mask_level_i,
    .irq_i, .port_out_i, .port_out_o, .wake_o, .cpu_run_o, .sys_clk_en_o, .osc_en_o, .rtc_en_o,
    .unit_run_o, .sys_control_0_o, .sys_control_1_o, .sys_control_2_o, .irq_o);
  swp_cpu_model u_cpu (.clk_i, .wake_i(wake_o), .halt_o(halt_exec_i),
    .mask_o(irq_mask_level_i), .irq_o(irq_i), .port_o(port_out_i));
  function automatic swp_pkg::swp_irq_s mk(input logic [2:0] l, input logic n, input logic x);
    return {1'b1, l, n, x, 1'b0, (n | x) ? 3'b111 : 3'b100};
  endfunction : mk
  task automatic wb(input logic [9:0] a, input logic wr, input logic [7:0] d);
    @(posedge clk_i);
    wb_adr_i <= {22'h0, a};
    wb_we_i  <= wr;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'h1;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin @(posedge clk_i); end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb
  task automatic rd(input logic [9:0] a, input logic [7:0] x, input string n);
    wb(a, 1'b0, 8'h00);
    `CHK(n, x, q[7:0])
  endtask : rd
  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(swp_pkg::PROT_STATUS_ADR, 8'h23, "status_rst");
    wb(swp_pkg::PROT_KEY_ADR, 1'b1, 8'h00);
    rd(swp_pkg::PROT_STATUS_ADR, 8'ha3, "protect_on");
    wb(swp_pkg::SYS_CTRL2_ADR, 1'b1, 8'h20);
    `CHK("guarded", 8'h2c, sys_control_2_o)
    wb(swp_pkg::SYS_CTRL0_ADR, 1'b1, 8'h11);
    wb(swp_pkg::SYS_CTRL1_ADR, 1'b1, 8'h22);
    `CHK("guarded0", swp_pkg::SYS_CTRL0_RST, sys_control_0_o)
    `CHK("guarded1", swp_pkg::SYS_CTRL1_RST, sys_control_1_o)
    rd(swp_pkg::IRQ_STAT_ADR, 8'h08, "blocked_flag");
    wb(swp_pkg::IDLE_EN_ADR, 1'b1, 8'h05);
    rd(swp_pkg::IDLE_EN_ADR, 8'h05, "other_write");
    wb(swp_pkg::PROT_STATUS_ADR, 1'b1, 8'h55);
    rd(swp_pkg::PROT_STATUS_ADR, 8'hd5, "flag_ro");
    wb(swp_pkg::PROT_KEY_ADR, 1'b1, swp_pkg::UNLOCK_CODE);
    rd(swp_pkg::PROT_STATUS_ADR, 8'h55, "protect_off");
    wb(swp_pkg::SYS_CTRL1_ADR, 1'b1, 8'h22);
    `CHK("open1", 8'h22, sys_control_1_o)
    rd(swp_pkg::SYS_CTRL0_ADR, swp_pkg::SYS_CTRL0_RST, "ctrl0_read");
    wb(10'h3fc, 1'b0, 8'h00);
    `CHK("unmapped", 1'b1, e)
    wb(swp_pkg::IRQ_STAT_ADR, 1'b1, 8'h0f);
    wb(swp_pkg::IRQ_MASK_ADR, 1'b1, 8'h01);
    foreach (lv[i]) begin
      wb(swp_pkg::SYS_CTRL2_ADR, 1'b1, {4'h2, lv[i], 2'b00});
      u_cpu.halt();
      repeat (8) @(posedge clk_i);
      p = port_out_o;
      `CHK("run", 1'b0, cpu_run_o)
      `CHK("sysclk", lv[i] == 2'b11, sys_clk_en_o)
      `CHK("osc", lv[i] != 2'b01, osc_en_o)
      `CHK("rtc", lv[i] != 2'b01, rtc_en_o)
      `CHK("units", (lv[i] == 2'b11) ? 13'h0005 : 13'h0000, unit_run_o)
      `CHK("irq_on", 1'b1, irq_o)
      wb(swp_pkg::IRQ_STAT_ADR, 1'b1, 8'h0f);
      `CHK("irq_off", 1'b0, irq_o)
      `CHK("port", p, port_out_o)
      rd(swp_pkg::STBY_STAT_ADR, {3'b000, lv[i], 3'b010}, "stby_stat");
      u_cpu.req(mk(3'd5, 1'b0, 1'b1), 3'd3, 40, c);
      `CHK("warm", lv[i] == 2'b01, c >= 8)
      `CHK("svc", 1'b1, u_cpu.last_svc)
      repeat (4) @(posedge clk_i);
    end
    wb(swp_pkg::SYS_CTRL2_ADR, 1'b1, 8'h20);
    u_cpu.halt();
    repeat (6) @(posedge clk_i);
    `CHK("none", 1'b1, cpu_run_o)
    wb(swp_pkg::SYS_CTRL2_ADR, 1'b1, 8'h2c);
    u_cpu.halt();
    w = u_cpu.wakes;
    u_cpu.req(mk(3'd1, 1'b0, 1'b0), 3'd5, 20, c);
    `CHK("masked", w, u_cpu.wakes)
    u_cpu.req(mk(3'd7, 1'b1, 1'b0), 3'd7, 40, c);
    `CHK("nmi", 1'b1, u_cpu.last_svc)
    wb(swp_pkg::SYS_CTRL2_ADR, 1'b1, 8'h28);
    u_cpu.halt();
    repeat (8) @(posedge clk_i);
    u_cpu.req(mk(3'd1, 1'b0, 1'b1), 3'd5, 40, c);
    `CHK("ext_masked", 1'b0, u_cpu.last_svc)
    repeat (4) @(posedge clk_i);
    u_cpu.halt();
    u_cpu.req(mk(3'd7, 1'b1, 1'b0), 3'd7, 1, c);
    repeat (8) @(posedge clk_i);
    w = u_cpu.wakes;
    u_cpu.req(mk(3'd3, 1'b0, 1'b1), 3'd2, 40, c);
    repeat (4) @(posedge clk_i);
    `CHK("two_wakes", w + 2, u_cpu.wakes)
    `CHK("order", 2'b10, u_cpu.hist)
    u_cpu.halt();
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("reset_exit", 1'b1, cpu_run_o)
    rd(swp_pkg::PROT_STATUS_ADR, 8'h23, "reinit");
    `CHK("sel_reinit", 8'h2c, sys_control_2_o)
    `CHK("ctrl1_reinit", swp_pkg::SYS_CTRL1_RST, sys_control_1_o)
    rd(swp_pkg::IDLE_EN_ADR, 8'h00, "idle_reinit");
    tally_and_finish();
  end
endmodule : test_standby_and_write_protect_ctrl
